//--- verilog/wdrs_pkg.sv
package wdrs_pkg;
   // register offsets on the serial register port
   localparam logic [6:0] WDRS_ADDR_WDCTL  = 7'h00;
   localparam logic [6:0] WDRS_ADDR_MSTAT  = 7'h03;

   // watchdog control fields
   localparam int         WDRS_MODE_MSB    = 7;
   localparam int         WDRS_MODE_LSB    = 5;
   localparam int         WDRS_PER_MSB     = 3;
   localparam int         WDRS_PER_LSB     = 0;
   localparam logic [2:0] WDRS_MODE_AUTO   = 3'h1;
   localparam logic [2:0] WDRS_MODE_TO     = 3'h2;
   localparam logic [2:0] WDRS_MODE_WIN    = 3'h4;
   localparam logic [3:0] WDRS_PER_8      = 4'h8;
   localparam logic [3:0] WDRS_PER_16     = 4'h1;
   localparam logic [3:0] WDRS_PER_32     = 4'h2;
   localparam logic [3:0] WDRS_PER_64     = 4'hB;
   localparam logic [3:0] WDRS_PER_128    = 4'h4;
   localparam logic [3:0] WDRS_PER_256    = 4'hD;
   localparam logic [3:0] WDRS_PER_1024   = 4'hE;
   localparam logic [3:0] WDRS_PER_4096   = 4'h7;
   localparam logic [2:0] WDRS_MODE_RST    = WDRS_MODE_TO;
   localparam logic [3:0] WDRS_PER_RST     = WDRS_PER_128;

   // main status fields
   localparam int         WDRS_OTW_BIT     = 6;
   localparam int         WDRS_NMS_BIT     = 5;

   // reset cause codes
   localparam logic [4:0] WDRS_RC_POWERON  = 5'h00;
   localparam logic [4:0] WDRS_RC_CANWAKE  = 5'h01;
   localparam logic [4:0] WDRS_RC_PINWAKE  = 5'h04;
   localparam logic [4:0] WDRS_RC_SLPOVF   = 5'h0C;
   localparam logic [4:0] WDRS_RC_DIAGWAKE = 5'h0D;
   localparam logic [4:0] WDRS_RC_EARLY    = 5'h0E;
   localparam logic [4:0] WDRS_RC_OVF      = 5'h0F;
   localparam logic [4:0] WDRS_RC_ILLMODE  = 5'h10;
   localparam logic [4:0] WDRS_RC_EXTRST   = 5'h11;
   localparam logic [4:0] WDRS_RC_OTEXIT   = 5'h12;
   localparam logic [4:0] WDRS_RC_UV       = 5'h13;
   localparam logic [4:0] WDRS_RC_ILLSLP   = 5'h14;
   localparam logic [4:0] WDRS_RC_FDERR    = 5'h16;

   // effective watchdog behaviour, off-timeout-window differ one bit per step
   typedef enum logic [1:0]
   {
      WDRS_EFF_OFF = 2'b00,
      WDRS_EFF_TO  = 2'b01,
      WDRS_EFF_WIN = 2'b11
   } wdrs_eff_t;

   // oscillator timing: 80 ns period
   localparam int         WDRS_OSC_PERIOD_NS = 80;
   localparam int         WDRS_NS_PER_MS     = 1000000;
   localparam int         WDRS_OSC_CYC_PER_MS = WDRS_NS_PER_MS / WDRS_OSC_PERIOD_NS;
endpackage : wdrs_pkg

//--- verilog/wdrs_top.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - main status bit 6 follows the overtemperature warning level, read-only.
// - main status bit 5 reads 1 from power-up until normal operation is reached.
// - reset cause 00000 after power-up, 00001 for bus wake from sleep.
// - reset cause 00100 wake pin, 01100 sleep timeout overflow, 01101 diagnostic wake.
// - reset cause 01110 early window trigger, 01111 window overflow or repeated timeout overflow.
// - reset cause 10001 external, 10010 overtemp exit, 10011 undervoltage, 10100, 10110.
// - window behaviour only in normal operation; trigger inside window restarts timer.
// - timeout behaviour runs continuously, any trigger restarts it; usable as cyclic wake.
// - mode in control bits 7:5; 001 autonomous, 010 timeout default, 100 window.
// - window code outside normal runs as timeout until normal is entered.
// - mode change written during normal operation forces reset, cause 10000.
// - period bits 3:0 pick one of eight redundantly coded periods, 8 to 4096 ms.
// - period defaults to 128 ms, code 0100, after reset.
// - one programmed period serves both window and timeout behaviour.
// - every valid control write, except a mode change in normal, is a trigger and restarts the timer.
// - written mode or period takes effect at once.
// - forced-run configuration keeps the watchdog off in every state.
// - window/timeout code: timeout in standby and sleep, selected one in normal.
// - autonomous: timeout in normal, standby only with wake pending; off in development mode.
// - window: early trigger or overflow resets the system; late trigger restarts.
// - timeout overflow sets fail flag; overflow with flag set resets; sleep overflow wakes.
// - invalid mode or period code abandons the write and flags a port failure.
module wdrs_top
   import wdrs_pkg::*;
#(
   parameter int P_OSC_CYC_PER_MS = WDRS_OSC_CYC_PER_MS
)
(
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_osc_clk,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [6:0] i_reg_addr,
   input  wire logic [7:0] i_reg_wdata,
   input  wire logic       i_op_normal,
   input  wire logic       i_op_standby,
   input  wire logic       i_op_sleep,
   input  wire logic       i_wake_pending,
   input  wire logic       i_forced_run_cfg,
   input  wire logic       i_devel_mode_cfg,
   input  wire logic       i_overheat_warn,
   input  wire logic       i_rst_evt,
   input  wire logic [4:0] i_rst_evt_code,
   input  wire logic       i_wd_fail_clr,
   output logic [7:0]      o_reg_rdata,
   output logic            o_reg_rvalid,
   output logic            o_reset_req,
   output logic            o_wake_req,
   output logic            o_spi_fail,
   output logic            o_wd_fail_flag
);

   if (P_OSC_CYC_PER_MS < 2 || P_OSC_CYC_PER_MS > 65535)
   begin : g_bad_osc
      $error("P_OSC_CYC_PER_MS out of range");
   end

   typedef struct packed {
      logic       ot_s1;
      logic       ot_s2;
      logic       early_s1;
      logic       early_s2;
      logic       early_s3;
      logic       ovf_s1;
      logic       ovf_s2;
      logic       ovf_s3;
      logic       trig_t;
      logic       init;
      logic [2:0] wd_mode_sel;
      logic [3:0] wd_period_sel;
      wdrs_eff_t  eff;
      logic       normal_not_yet_reached;
      logic       overheat_warning_flag;
      logic [4:0] reset_cause;
      logic       wd_fail_flag;
      logic       rst_req;
      logic       wake;
      logic       spi_fail;
      logic [7:0] rdata;
      logic       rvalid;
   } wdrs_ref_t;
   typedef struct packed {
      logic       rst_s1;
      logic       rst_s2;
      logic       trig_s1;
      logic       trig_s2;
      logic       trig_s3;
      logic [1:0] eff_s1;
      logic [1:0] eff_s2;
      logic [3:0] per;
      logic [15:0] pre;
      logic [12:0] ms;
      logic       early_t;
      logic       ovf_t;
   } wdrs_osc_t;
   wdrs_ref_t ref_r;
   wdrs_ref_t ref_nxt;
   wdrs_osc_t osc_r;
   wdrs_osc_t osc_nxt;

   function automatic logic [12:0] wdrs_per_ms(input logic [3:0] code);
      logic [12:0] ms;
      ms = 13'h0000;
      unique case (code)
         WDRS_PER_8    : ms = 13'h0008;
         WDRS_PER_16   : ms = 13'h0010;
         WDRS_PER_32   : ms = 13'h0020;
         WDRS_PER_64   : ms = 13'h0040;
         WDRS_PER_128  : ms = 13'h0080;
         WDRS_PER_256  : ms = 13'h0100;
         WDRS_PER_1024 : ms = 13'h0400;
         WDRS_PER_4096 : ms = 13'h1000;
         default       : ms = 13'h0000;
      endcase
      return ms;
   endfunction : wdrs_per_ms
   function automatic logic wdrs_mode_ok(input logic [2:0] code);
      return code == WDRS_MODE_AUTO || code == WDRS_MODE_TO || code == WDRS_MODE_WIN;
   endfunction : wdrs_mode_ok
   logic       wr_ctl;
   logic [2:0] wr_mode;
   logic [3:0] wr_per;
   logic       wr_ok;
   logic       early_evt;
   logic       ovf_evt;

   assign wr_ctl  = i_reg_wr && i_reg_addr == WDRS_ADDR_WDCTL;
   assign wr_mode = i_reg_wdata[WDRS_MODE_MSB:WDRS_MODE_LSB];
   assign wr_per  = i_reg_wdata[WDRS_PER_MSB:WDRS_PER_LSB];
   assign wr_ok   = wdrs_mode_ok(wr_mode) && wdrs_per_ms(wr_per) != 13'h0000;
   assign early_evt = ref_r.early_s2 ^ ref_r.early_s3;
   assign ovf_evt   = ref_r.ovf_s2 ^ ref_r.ovf_s3;

   // host clock side: registers, causes, effective behaviour
   always_comb
   begin
      ref_nxt = ref_r;
      ref_nxt.ot_s1    = i_overheat_warn;
      ref_nxt.ot_s2    = ref_r.ot_s1;
      ref_nxt.early_s1 = osc_r.early_t;
      ref_nxt.early_s2 = ref_r.early_s1;
      ref_nxt.early_s3 = ref_r.early_s2;
      ref_nxt.ovf_s1   = osc_r.ovf_t;
      ref_nxt.ovf_s2   = ref_r.ovf_s1;
      ref_nxt.ovf_s3   = ref_r.ovf_s2;
      ref_nxt.rst_req  = 1'b0;
      ref_nxt.wake     = 1'b0;
      ref_nxt.spi_fail = 1'b0;
      ref_nxt.rvalid   = i_reg_rd;
      ref_nxt.init     = 1'b1;
      ref_nxt.overheat_warning_flag = ref_r.ot_s2;
      if (i_op_normal)
      begin
         ref_nxt.normal_not_yet_reached = 1'b0;
      end
      // strap caught after release: development mode starts autonomous
      if (!ref_r.init && i_devel_mode_cfg)
      begin
         ref_nxt.wd_mode_sel = WDRS_MODE_AUTO;
      end
      if (i_rst_evt)
      begin
         ref_nxt.reset_cause = i_rst_evt_code;
      end
      if (wr_ctl)
      begin
         if (!wr_ok)
         begin
            ref_nxt.spi_fail = 1'b1;
         end
         else if (i_op_normal && wr_mode != ref_r.wd_mode_sel)
         begin
            // mode is kept; the device goes to reset instead
            ref_nxt.rst_req     = 1'b1;
            ref_nxt.reset_cause = WDRS_RC_ILLMODE;
         end
         else
         begin
            ref_nxt.wd_mode_sel   = wr_mode;
            ref_nxt.wd_period_sel = wr_per;
            ref_nxt.trig_t        = ~ref_r.trig_t;
         end
      end
      if (early_evt)
      begin
         ref_nxt.rst_req     = 1'b1;
         ref_nxt.reset_cause = WDRS_RC_EARLY;
      end
      else if (ovf_evt)
      begin
         if (ref_r.eff == WDRS_EFF_WIN || ref_r.wd_fail_flag)
         begin
            ref_nxt.rst_req     = 1'b1;
            ref_nxt.reset_cause = WDRS_RC_OVF;
         end
         else if (i_op_sleep)
         begin
            ref_nxt.wake        = 1'b1;
            ref_nxt.reset_cause = WDRS_RC_SLPOVF;
         end
      end
      // set wins over a clear in the same cycle
      if (i_wd_fail_clr)
      begin
         ref_nxt.wd_fail_flag = 1'b0;
      end
      if (ovf_evt && ref_r.eff == WDRS_EFF_TO)
      begin
         ref_nxt.wd_fail_flag = 1'b1;
      end
      ref_nxt.eff = WDRS_EFF_OFF;
      if (!i_forced_run_cfg)
      begin
         if (ref_nxt.wd_mode_sel == WDRS_MODE_AUTO)
         begin
            if (!i_devel_mode_cfg && (i_op_normal || (i_op_standby && i_wake_pending)))
            begin
               ref_nxt.eff = WDRS_EFF_TO;
            end
         end
         else if (i_op_normal)
         begin
            ref_nxt.eff = ref_nxt.wd_mode_sel == WDRS_MODE_WIN ? WDRS_EFF_WIN : WDRS_EFF_TO;
         end
         else if (i_op_standby || i_op_sleep)
         begin
            ref_nxt.eff = WDRS_EFF_TO;
         end
      end
      ref_nxt.rdata = 8'h00;
      if (i_reg_rd && i_reg_addr == WDRS_ADDR_WDCTL)
      begin
         ref_nxt.rdata = {ref_r.wd_mode_sel, 1'b0, ref_r.wd_period_sel};
      end
      else if (i_reg_rd && i_reg_addr == WDRS_ADDR_MSTAT)
      begin
         ref_nxt.rdata = {1'b0, ref_r.overheat_warning_flag, ref_r.normal_not_yet_reached, ref_r.reset_cause};
      end
      if (!i_rst_n)
      begin
         ref_nxt = '0;
         ref_nxt.wd_mode_sel            = WDRS_MODE_RST;
         ref_nxt.wd_period_sel          = WDRS_PER_RST;
         ref_nxt.normal_not_yet_reached = 1'b1;
         ref_nxt.reset_cause            = WDRS_RC_POWERON;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      ref_r <= ref_nxt;
   end
   // oscillator side: the timer itself
   logic [12:0] per_ms;
   logic        trig_evt;
   logic        ms_tick;
   logic [1:0]  eff_o;

   assign per_ms   = wdrs_per_ms(osc_r.per);
   assign trig_evt = osc_r.trig_s2 ^ osc_r.trig_s3;
   assign ms_tick  = osc_r.pre == 16'(P_OSC_CYC_PER_MS - 1);
   assign eff_o    = osc_r.eff_s2;

   always_comb
   begin
      osc_nxt = osc_r;
      osc_nxt.rst_s1  = i_rst_n;
      osc_nxt.rst_s2  = osc_r.rst_s1;
      osc_nxt.trig_s1 = ref_r.trig_t;
      osc_nxt.trig_s2 = osc_r.trig_s1;
      osc_nxt.trig_s3 = osc_r.trig_s2;
      osc_nxt.eff_s1  = ref_r.eff;
      osc_nxt.eff_s2  = osc_r.eff_s1;
      // period word was settled two edges before its toggle arrives
      if (trig_evt)
      begin
         osc_nxt.per = ref_r.wd_period_sel;
      end
      if (eff_o == WDRS_EFF_OFF)
      begin
         osc_nxt.pre = 16'h0000;
         osc_nxt.ms  = 13'h0000;
      end
      else if (trig_evt)
      begin
         if (eff_o == WDRS_EFF_WIN && osc_r.ms < (per_ms >> 1))
         begin
            osc_nxt.early_t = ~osc_r.early_t;
         end
         osc_nxt.pre = 16'h0000;
         osc_nxt.ms  = 13'h0000;
      end
      else if (ms_tick)
      begin
         osc_nxt.pre = 16'h0000;
         if (osc_r.ms == per_ms - 13'h0001)
         begin
            osc_nxt.ms    = 13'h0000;
            osc_nxt.ovf_t = ~osc_r.ovf_t;
         end
         else
         begin
            osc_nxt.ms = osc_r.ms + 13'h0001;
         end
      end
      else
      begin
         osc_nxt.pre = osc_r.pre + 16'h0001;
      end
      if (!osc_r.rst_s2)
      begin
         osc_nxt        = '0;
         osc_nxt.rst_s1 = i_rst_n;
         osc_nxt.rst_s2 = osc_r.rst_s1;
         osc_nxt.per    = WDRS_PER_RST;
      end
   end

   always_ff @(posedge i_osc_clk)
   begin
      osc_r <= osc_nxt;
   end

   assign o_reg_rdata    = ref_r.rdata;
   assign o_reg_rvalid   = ref_r.rvalid;
   assign o_reset_req    = ref_r.rst_req;
   assign o_wake_req     = ref_r.wake;
   assign o_spi_fail     = ref_r.spi_fail;
   assign o_wd_fail_flag = ref_r.wd_fail_flag;

   default clocking wdrs_cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);

   overheat_track_a: assert property ($past(i_rst_n, 3) |-> ref_r.overheat_warning_flag == $past(i_overheat_warn, 3))
      else $error("overheat flag does not follow pin");
   normal_seen_a: assert property (i_op_normal |=> !ref_r.normal_not_yet_reached ##1 !ref_r.normal_not_yet_reached)
      else $error("normal status not cleared");
   poweron_cause_a: assert property (!$past(i_rst_n) |-> ref_r.reset_cause == WDRS_RC_POWERON && ref_r.normal_not_yet_reached)
      else $error("power-up status wrong");
   bad_write_a: assert property (wr_ctl && !wr_ok |=> o_spi_fail && $stable(ref_r.wd_mode_sel) && $stable(ref_r.wd_period_sel))
      else $error("invalid write not abandoned");
   illegal_mode_a: assert property (wr_ctl && wr_ok && i_op_normal && wr_mode != ref_r.wd_mode_sel
                                    |=> o_reset_req && ref_r.reset_cause == WDRS_RC_ILLMODE)
      else $error("mode change in normal not reset");
   write_apply_a: assert property (wr_ctl && wr_ok && !(i_op_normal && wr_mode != ref_r.wd_mode_sel)
                                   |=> ref_r.wd_period_sel == $past(wr_per) && ref_r.trig_t != $past(ref_r.trig_t))
      else $error("valid write not applied as trigger");
   forced_off_a: assert property (i_forced_run_cfg |=> ref_r.eff == WDRS_EFF_OFF)
      else $error("watchdog runs with forced-run set");
   win_outside_a: assert property (!i_forced_run_cfg && !i_op_normal && (i_op_standby || i_op_sleep)
                                   && ref_nxt.wd_mode_sel == WDRS_MODE_WIN |=> ref_r.eff == WDRS_EFF_TO)
      else $error("window not downgraded outside normal");
   auto_devel_a: assert property (ref_nxt.wd_mode_sel == WDRS_MODE_AUTO && i_devel_mode_cfg |=> ref_r.eff == WDRS_EFF_OFF)
      else $error("autonomous runs in development mode");
   early_reset_a: assert property (early_evt |=> o_reset_req && ref_r.reset_cause == WDRS_RC_EARLY)
      else $error("early trigger did not reset");

   early_cov: cover property (early_evt);
   ovf_reset_cov: cover property (ovf_evt && ref_r.wd_fail_flag);
   sleep_wake_cov: cover property (o_wake_req);
   bad_write_cov: cover property (wr_ctl && !wr_ok);

endmodule : wdrs_top
`default_nettype wire

//--- dv/wdrs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module wdrs_host_model
(
   input  wire logic       i_ref_clk,
   input  wire logic [7:0] i_reg_rdata,
   input  wire logic       i_reg_rvalid,
   output logic            o_reg_wr,
   output logic            o_reg_rd,
   output logic [6:0]      o_reg_addr,
   output logic [7:0]      o_reg_wdata
);
   initial
   begin
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = 7'h55;
      o_reg_wdata = 8'hAA;
   end

   // callers change the mode while standby is held, and once in normal to force a reset
   task automatic wr(input logic [6:0] addr, input logic [7:0] data);
      @(posedge i_ref_clk);
      o_reg_wr    <= 1'b1;
      o_reg_addr  <= addr;
      o_reg_wdata <= data;
      @(posedge i_ref_clk);
      o_reg_wr    <= 1'b0;
      // released lines carry garbage, never the last value
      o_reg_addr  <= ~addr;
      o_reg_wdata <= ~data;
      #1;
   endtask : wr

   task automatic rd(input logic [6:0] addr, output logic [7:0] data);
      @(posedge i_ref_clk);
      o_reg_rd   <= 1'b1;
      o_reg_addr <= addr;
      @(posedge i_ref_clk);
      o_reg_rd   <= 1'b0;
      o_reg_addr <= ~addr;
      #1;
      data = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 'x;
   endtask : rd
endmodule : wdrs_host_model
`default_nettype wire

//--- dv/test_wdrs_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_wdrs_top
   import wdrs_pkg::*;
;
   localparam int OSC_MS = 4;
   // 8 ms period in ref cycles, waits derived from it
   localparam int PER8   = 8 * OSC_MS * WDRS_OSC_PERIOD_NS / 50;
   localparam int SHORT  = PER8 * 2 / 3;
   localparam int LATE   = PER8 * 3 / 4;
   localparam int OVER   = PER8 + 24;
   localparam int DOUBLE = 2 * PER8 + 20;

   logic       ref_clk = 1'b0;
   logic       osc_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       reg_wr, reg_rd, rvalid, reset_req, wake_req, spi_fail, fail_flag;
   logic [6:0] reg_addr;
   logic [7:0] reg_wdata, rdata;
   logic       normal = 1'b0, standby = 1'b0, sleep = 1'b0, wake = 1'b0;
   logic       forced = 1'b0, devel = 1'b0, warn = 1'b0, evt = 1'b0, fclr = 1'b0;
   logic [4:0] evt_code = 5'h00;
   int         bad_count = 0, checks_done = 0, rst_cnt = 0, wake_cnt = 0, n0;
   logic [3:0] pers [8] = '{WDRS_PER_8, WDRS_PER_16, WDRS_PER_32, WDRS_PER_64,
                            WDRS_PER_128, WDRS_PER_256, WDRS_PER_1024, WDRS_PER_4096};
   logic [2:0] modes [3] = '{WDRS_MODE_AUTO, WDRS_MODE_WIN, WDRS_MODE_TO};
   logic [4:0] codes [8] = '{WDRS_RC_CANWAKE, WDRS_RC_PINWAKE, WDRS_RC_DIAGWAKE, WDRS_RC_EXTRST,
                             WDRS_RC_OTEXIT, WDRS_RC_UV, WDRS_RC_ILLSLP, WDRS_RC_FDERR};

   always #25 ref_clk = ~ref_clk;
   always #40 osc_clk = ~osc_clk;

   always @(posedge ref_clk)
   begin
      if (reset_req === 1'b1) rst_cnt++;
      if (wake_req === 1'b1) wake_cnt++;
   end

   wdrs_host_model u_host
   (
      .i_ref_clk    (ref_clk),
      .i_reg_rdata  (rdata),
      .i_reg_rvalid (rvalid),
      .o_reg_wr     (reg_wr),
      .o_reg_rd     (reg_rd),
      .o_reg_addr   (reg_addr),
      .o_reg_wdata  (reg_wdata)
   );

   wdrs_top #(.P_OSC_CYC_PER_MS(OSC_MS)) u_dut
   (
      .i_ref_clk        (ref_clk),
      .i_rst_n          (rst_n),
      .i_osc_clk        (osc_clk),
      .i_reg_wr         (reg_wr),
      .i_reg_rd         (reg_rd),
      .i_reg_addr       (reg_addr),
      .i_reg_wdata      (reg_wdata),
      .i_op_normal      (normal),
      .i_op_standby     (standby),
      .i_op_sleep       (sleep),
      .i_wake_pending   (wake),
      .i_forced_run_cfg (forced),
      .i_devel_mode_cfg (devel),
      .i_overheat_warn  (warn),
      .i_rst_evt        (evt),
      .i_rst_evt_code   (evt_code),
      .i_wd_fail_clr    (fclr),
      .o_reg_rdata      (rdata),
      .o_reg_rvalid     (rvalid),
      .o_reset_req      (reset_req),
      .o_wake_req       (wake_req),
      .o_spi_fail       (spi_fail),
      .o_wd_fail_flag   (fail_flag)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc

   task automatic rchk(input logic [6:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(addr, d);
      check(d, exp);
   endtask : rchk

   task automatic fchk(input logic exp);
      check({7'h00, fail_flag}, {7'h00, exp});
   endtask : fchk

   task automatic clr();
      cyc(1);
      fclr <= 1'b1;
      cyc(1);
      fclr <= 1'b0;
   endtask : clr

   task automatic test_done();
      if (bad_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   initial
   begin
      #400000;
      bad_count++;
      test_done();
   end

   initial
   begin
      cyc(8);
      rst_n   <= 1'b1;
      standby <= 1'b1;
      cyc(2);
      rchk(WDRS_ADDR_WDCTL, {WDRS_MODE_RST, 1'b0, WDRS_PER_RST});
      rchk(WDRS_ADDR_MSTAT, {3'b001, WDRS_RC_POWERON});
      rchk(7'h7F, 8'h00);
      warn <= 1'b1;
      cyc(6);
      rchk(WDRS_ADDR_MSTAT, 8'h60);
      u_host.wr(WDRS_ADDR_MSTAT, 8'h00);
      rchk(WDRS_ADDR_MSTAT, 8'h60);
      warn <= 1'b0;
      cyc(6);
      rchk(WDRS_ADDR_MSTAT, 8'h20);
      foreach (pers[i])
      begin
         u_host.wr(WDRS_ADDR_WDCTL, {WDRS_MODE_TO, 1'b0, pers[i]});
         rchk(WDRS_ADDR_WDCTL, {WDRS_MODE_TO, 1'b0, pers[i]});
      end
      foreach (modes[i])
      begin
         u_host.wr(WDRS_ADDR_WDCTL, {modes[i], 1'b0, WDRS_PER_8});
         rchk(WDRS_ADDR_WDCTL, {modes[i], 1'b0, WDRS_PER_8});
      end
      // invalid mode 011, then invalid period 1001
      u_host.wr(WDRS_ADDR_WDCTL, 8'h68);
      check({7'h00, spi_fail}, 8'h01);
      u_host.wr(WDRS_ADDR_WDCTL, 8'h49);
      check({7'h00, spi_fail}, 8'h01);
      rchk(WDRS_ADDR_WDCTL, 8'h48);
      // timeout: retriggers hold it off, then two overflows
      for (int i = 0; i < 4; i++)
      begin
         u_host.wr(WDRS_ADDR_WDCTL, 8'h48);
         cyc(SHORT);
      end
      fchk(1'b0);
      n0 = rst_cnt;
      cyc(OVER - SHORT);
      fchk(1'b1);
      cyc(DOUBLE - OVER);
      check(8'(rst_cnt - n0), 8'h01);
      rchk(WDRS_ADDR_MSTAT, {3'b001, WDRS_RC_OVF});
      // sleep overflow acts as cyclic wake
      u_host.wr(WDRS_ADDR_WDCTL, 8'h48);
      clr();
      standby <= 1'b0;
      sleep   <= 1'b1;
      n0 = wake_cnt;
      cyc(OVER);
      check(8'(wake_cnt - n0), 8'h01);
      rchk(WDRS_ADDR_MSTAT, {3'b001, WDRS_RC_SLPOVF});
      // window code chosen in standby, armed on entering normal
      sleep   <= 1'b0;
      standby <= 1'b1;
      clr();
      u_host.wr(WDRS_ADDR_WDCTL, 8'h88);
      standby <= 1'b0;
      normal  <= 1'b1;
      n0 = rst_cnt;
      cyc(LATE);
      u_host.wr(WDRS_ADDR_WDCTL, 8'h88);
      cyc(8);
      check(8'(rst_cnt - n0), 8'h00);
      u_host.wr(WDRS_ADDR_WDCTL, 8'h48);
      check({7'h00, reset_req}, 8'h01);
      rchk(WDRS_ADDR_WDCTL, 8'h88);
      rchk(WDRS_ADDR_MSTAT, {3'b000, WDRS_RC_ILLMODE});
      u_host.wr(WDRS_ADDR_WDCTL, 8'h88);
      cyc(12);
      rchk(WDRS_ADDR_MSTAT, {3'b000, WDRS_RC_EARLY});
      cyc(OVER);
      rchk(WDRS_ADDR_MSTAT, {3'b000, WDRS_RC_OVF});
      // configurations that keep the timer off
      normal  <= 1'b0;
      standby <= 1'b1;
      forced  <= 1'b1;
      u_host.wr(WDRS_ADDR_WDCTL, 8'h48);
      cyc(8);
      clr();
      n0 = rst_cnt;
      cyc(DOUBLE);
      fchk(1'b0);
      check(8'(rst_cnt - n0), 8'h00);
      forced <= 1'b0;
      u_host.wr(WDRS_ADDR_WDCTL, 8'h28);
      cyc(DOUBLE);
      fchk(1'b0);
      devel <= 1'b1;
      wake  <= 1'b1;
      cyc(DOUBLE);
      fchk(1'b0);
      devel <= 1'b0;
      cyc(OVER);
      fchk(1'b1);
      wake <= 1'b0;
      cyc(8);
      foreach (codes[i])
      begin
         evt      <= 1'b1;
         evt_code <= codes[i];
         cyc(1);
         evt <= 1'b0;
         rchk(WDRS_ADDR_MSTAT, {3'b000, codes[i]});
      end
      test_done();
   end
endmodule : test_wdrs_top
`default_nettype wire
